// [hdl/pml_mode_link_top.sv]
/*
  Mode control and link-status logic of a serial-MII / gigabit coding
  sublayer: mode registers, auto-negotiation control machine, link good,
  transmit gating, rate select, interrupt and an Avalon-MM slave.
  Assumes receive status inputs come from data-path logic on CLOCK.
*/
// Our own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
module pml_mode_link_top
  import pml_pkg::*;
#(
  parameter int LT_GBE_CYC = PML_LT_GBE_CYC,
  parameter int LT_SGMII_CYC = PML_LT_SGMII_CYC,
  parameter int LT_SHORT_CYC = PML_LT_SHORT_CYC
) (
  input wire logic CLOCK,
  input wire logic RESETN,
  // Avalon-MM slave
  input wire logic [3:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] WRITEDATA,
  input wire logic [3:0] BYTEENABLE,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  // Receive side status
  input wire logic RX_SYNC,
  input wire logic RX_INVALID,
  input wire logic RX_CONFIG_VALID,
  input wire logic RX_CONFIG_ACK,
  input wire logic RX_IDLE,
  // Mode and status outputs
  output logic LINK_GOOD,
  output logic AN_COMPLETE,
  output logic XMIT_AUTONEG,
  output logic TX_IGNORE_GMII,
  output logic [1:0] RATE_SEL,
  output logic GBE_MODE,
  output logic PHY_SIDE,
  output logic IRQ
);

  // Assertion clock and reset for the whole module
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  // ************************************************************
  // Parameter check
  // ************************************************************
  if (LT_SHORT_CYC >= LT_SGMII_CYC) begin : g_chk
    $error("debug link timer must be shorter than normal");
  end

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [7:0] ctrl_q; // Control register
  logic [PML_NUM_EVENTS-1:0] ints_q; // Sticky events
  logic [PML_NUM_EVENTS-1:0] intm_q; // Event mask
  logic [PML_NUM_EVENTS-1:0] events; // Event pulses this cycle
  logic restart_q; // Restart pulse from software
  logic req; // Bus request present
  logic acc; // Bus request accepted this edge
  logic wr_acc; // Write accepted
  logic [31:0] rd_d; // Read mux
  pml_an_state_t state_q; // Autoneg state
  pml_an_state_t state_d; // Next autoneg state
  logic tmr_start; // Link timer start pulse
  logic tmr_done; // Link timer expired
  logic sync_q; // Last receive sync
  logic an_en; // Autoneg enable field
  logic gbe; // Gigabit mode field
  logic unidir; // Unidirectional field
  logic [1:0] rate_sw; // Speed select field

  assign an_en = ctrl_q[PML_C_AN_EN];
  assign gbe = ctrl_q[PML_C_GBE];
  assign unidir = ctrl_q[PML_C_UNIDIR];
  assign rate_sw = ctrl_q[PML_C_RATE_LO +: 2];

  // ************************************************************
  // Avalon-MM slave
  // ************************************************************
  assign req = READ || WRITE;
  assign acc = req && !WAITREQUEST;
  assign wr_acc = WRITE && !WAITREQUEST && BYTEENABLE[0];

  // Waitrequest drops for one cycle per request
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      WAITREQUEST <= 1'b1;
    end else if (req && WAITREQUEST) begin
      WAITREQUEST <= 1'b0;
    end else begin
      WAITREQUEST <= 1'b1;
    end
  end

  // Read mux, unmapped reads as zero
  always_comb begin
    rd_d = 32'h0;
    if (ADDRESS == PML_CTRL_OFS) begin
      rd_d[7:0] = ctrl_q;
    end else if (ADDRESS == PML_STAT_OFS) begin
      rd_d[PML_S_LINK] = LINK_GOOD;
      rd_d[PML_S_AN_DONE] = AN_COMPLETE;
      rd_d[PML_S_SYNC] = sync_q;
      rd_d[PML_S_RATE_LO +: 2] = RATE_SEL;
    end else if (ADDRESS == PML_INTS_OFS) begin
      rd_d[PML_NUM_EVENTS-1:0] = ints_q;
    end else if (ADDRESS == PML_INTM_OFS) begin
      rd_d[PML_NUM_EVENTS-1:0] = intm_q;
    end
  end

  // Read data captured while waitrequest falls
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      READDATA <= 32'h0;
    end else if (READ && WAITREQUEST) begin
      READDATA <= rd_d;
    end
  end

  // ************************************************************
  // Control register
  // ************************************************************
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      ctrl_q <= PML_CTRL_RST;
    end else if (wr_acc && ADDRESS == PML_CTRL_OFS) begin
      ctrl_q <= WRITEDATA[7:0];
      ctrl_q[PML_C_AN_RST] <= 1'b0;
    end
  end

  // Restart bit acts as a one-cycle pulse
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= wr_acc && (ADDRESS == PML_CTRL_OFS) && WRITEDATA[PML_C_AN_RST];
    end
  end

  // ************************************************************
  // Link timer
  // ************************************************************
  pml_link_timer #(
    .GBE_CYC(LT_GBE_CYC),
    .SGMII_CYC(LT_SGMII_CYC),
    .SHORT_CYC(LT_SHORT_CYC)
  ) u_timer (
    .clk(CLOCK),
    .rst_n(RESETN),
    .start(tmr_start),
    .short_mode(ctrl_q[PML_C_DBG_TMR]),
    .gbe_mode(gbe),
    .done(tmr_done)
  );

  // Timer restarts on entry to every timed state
  assign tmr_start = (state_d != state_q) &&
    (state_d == PML_AN_RESTART || state_d == PML_COMPLETE_ACK ||
     state_d == PML_IDLE_DET);

  // ************************************************************
  // Autoneg control machine
  // ************************************************************
  always_comb begin
    state_d = state_q;
    if (!an_en) begin
      state_d = PML_DISABLE_LINK_OK;
    end else if (restart_q || !RX_SYNC) begin
      state_d = PML_AN_ENABLE;
    end else begin
      case (state_q)
        PML_AN_ENABLE: begin
          state_d = PML_AN_RESTART;
        end
        PML_AN_RESTART: begin
          // Send breaklink until the timer runs out
          if (tmr_done) begin
            state_d = PML_ABILITY_DET;
          end
        end
        PML_ABILITY_DET: begin
          if (RX_CONFIG_VALID) begin
            state_d = PML_ACK_DET;
          end
        end
        PML_ACK_DET: begin
          if (RX_CONFIG_ACK) begin
            state_d = PML_COMPLETE_ACK;
          end
        end
        PML_COMPLETE_ACK: begin
          if (tmr_done) begin
            state_d = PML_IDLE_DET;
          end
        end
        PML_IDLE_DET: begin
          // Idles must be seen once the timer is out
          if (tmr_done && RX_IDLE) begin
            state_d = PML_LINK_OK;
          end
        end
        PML_LINK_OK: begin
          // Partner sending configuration again means a restart
          if (RX_CONFIG_VALID) begin
            state_d = PML_AN_ENABLE;
          end
        end
        default: begin
          state_d = PML_AN_ENABLE;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      state_q <= PML_AN_ENABLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ************************************************************
  // Link status outputs
  // ************************************************************
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      LINK_GOOD <= 1'b0;
      AN_COMPLETE <= 1'b0;
      XMIT_AUTONEG <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      LINK_GOOD <= (an_en && state_q == PML_LINK_OK) ||
        (!an_en && state_q == PML_DISABLE_LINK_OK);
      AN_COMPLETE <= an_en && state_q == PML_LINK_OK;
      XMIT_AUTONEG <= an_en && state_q != PML_LINK_OK &&
        state_q != PML_DISABLE_LINK_OK;
      sync_q <= RX_SYNC;
    end
  end

  // ************************************************************
  // Mode outputs
  // ************************************************************
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      RATE_SEL <= PML_RATE_1G;
      GBE_MODE <= 1'b0;
      PHY_SIDE <= 1'b0;
    end else begin
      GBE_MODE <= gbe;
      // Role matters only for serial-MII autoneg
      PHY_SIDE <= !gbe && ctrl_q[PML_C_PHY_SIDE];
      if (gbe) begin
        RATE_SEL <= PML_RATE_1G;
      end else begin
        RATE_SEL <= rate_sw;
      end
    end
  end

  // Transmit gating by receive faults unless unidirectional
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      TX_IGNORE_GMII <= 1'b0;
    end else if (unidir) begin
      TX_IGNORE_GMII <= 1'b0;
    end else begin
      TX_IGNORE_GMII <= !RX_SYNC || RX_INVALID ||
        (an_en && (state_q == PML_AN_ENABLE || state_q == PML_AN_RESTART));
    end
  end

  // ************************************************************
  // Interrupts
  // ************************************************************
  always_comb begin
    events = '0;
    events[PML_E_UP] = !LINK_GOOD && (an_en ? state_q == PML_LINK_OK :
      state_q == PML_DISABLE_LINK_OK);
    events[PML_E_DOWN] = LINK_GOOD && !(an_en ? state_q == PML_LINK_OK :
      state_q == PML_DISABLE_LINK_OK);
    events[PML_E_SYNC_LOST] = sync_q && !RX_SYNC;
  end

  // Sticky bits, set wins over a write-one clear
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      ints_q <= '0;
    end else if (wr_acc && ADDRESS == PML_INTS_OFS) begin
      ints_q <= (ints_q & ~WRITEDATA[PML_NUM_EVENTS-1:0]) | events;
    end else begin
      ints_q <= ints_q | events;
    end
  end

  // Mask register
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      intm_q <= '0;
    end else if (wr_acc && ADDRESS == PML_INTM_OFS) begin
      intm_q <= WRITEDATA[PML_NUM_EVENTS-1:0];
    end
  end

  // Interrupt line
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(ints_q & intm_q);
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  sequence req_waiting_s;
    req && WAITREQUEST;
  endsequence
  sequence req_answered_s;
    ##[1:2] !WAITREQUEST;
  endsequence

  bus_answer_a: assert property (req_waiting_s |-> req_answered_s)
    else $error("bus request not answered");
  link_enabled_a: assert property (an_en && $past(an_en) |->
    (LINK_GOOD == ($past(state_q) == PML_LINK_OK)))
    else $error("link good wrong with autoneg on");
  link_disabled_a: assert property (!an_en && $past(!an_en) |->
    (LINK_GOOD == ($past(state_q) == PML_DISABLE_LINK_OK)))
    else $error("link good wrong with autoneg off");
  unidir_tx_a: assert property (unidir |=> !TX_IGNORE_GMII)
    else $error("transmit gated in unidirectional mode");
  sync_gate_a: assert property (RESETN && !unidir && !RX_SYNC |=> TX_IGNORE_GMII)
    else $error("transmit not gated on sync loss");
  rate_gbe_a: assert property (gbe |=> RATE_SEL == PML_RATE_1G)
    else $error("gigabit mode not at full rate");
  rate_sgmii_a: assert property (!gbe |=> RATE_SEL == $past(rate_sw))
    else $error("serial-MII rate not followed");
  an_disable_a: assert property (!an_en |=> state_q == PML_DISABLE_LINK_OK)
    else $error("autoneg ran while disabled");
  an_restart_a: assert property (restart_q && an_en |=>
    state_q == PML_AN_ENABLE ##1 state_q == PML_AN_RESTART || !RX_SYNC || !an_en)
    else $error("restart did not restart autoneg");
  role_out_a: assert property (1'b1 |=> PHY_SIDE ==
    (!$past(gbe) && $past(ctrl_q[PML_C_PHY_SIDE])))
    else $error("role output wrong");
  reset_out_a: assert property (@(posedge CLOCK) disable iff (1'b0)
    !RESETN |=> !LINK_GOOD && !IRQ && WAITREQUEST && state_q == PML_AN_ENABLE)
    else $error("reset did not clear outputs");
  irq_level_a: assert property (1'b1 |=> IRQ == $past(|(ints_q & intm_q)))
    else $error("interrupt not raised");

endmodule // pml_mode_link_top

// [common/pml_pkg.sv]
/*
  Constants, register map and types shared by the mode control and
  link-status block and its link timer.
  Assumes a 25 MHz system clock and a 32-bit Avalon-MM register bus.
*/
// Summary of operation
// - Unidirectional override keeps transmit path always running
// - Otherwise receive faults may gate transmit input
// - Autoneg enabled: link good only in LINK_OK
// - Autoneg disabled: link good only in DISABLE_LINK_OK
// - Low global reset resets all logic
// - Role select: 0 MAC side, 1 PHY side
// - Coding select: 0 serial-MII, 1 gigabit
// - Speed select 10/01/00 gives 1G/100M/10M
// - Gigabit mode forces full rate, ignores speed
// - Debug timer input makes link timer short
// - Autoneg machine runs only while enable high
// - Restart forces autoneg back to its start
package pml_pkg;

  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam logic [3:0] PML_CTRL_OFS = 4'h0; // Control register
  localparam logic [3:0] PML_STAT_OFS = 4'h4; // Status register
  localparam logic [3:0] PML_INTS_OFS = 4'h8; // Sticky event bits
  localparam logic [3:0] PML_INTM_OFS = 4'hc; // Event mask

  // ************************************************************
  // Control field positions
  // ************************************************************
  localparam int PML_C_AN_EN = 0; // Autoneg enable
  localparam int PML_C_AN_RST = 1; // Autoneg restart, self clearing
  localparam int PML_C_UNIDIR = 2; // Unidirectional override
  localparam int PML_C_DBG_TMR = 3; // Short link timer
  localparam int PML_C_PHY_SIDE = 4; // Serial-MII role
  localparam int PML_C_GBE = 5; // Gigabit coding mode
  localparam int PML_C_RATE_LO = 6; // Speed select, two bits

  // ************************************************************
  // Status and event field positions
  // ************************************************************
  localparam int PML_S_LINK = 0; // Link good
  localparam int PML_S_AN_DONE = 1; // Autoneg complete
  localparam int PML_S_SYNC = 2; // Receive sync
  localparam int PML_S_RATE_LO = 8; // Effective rate, two bits
  localparam int PML_E_UP = 0; // Link came up
  localparam int PML_E_DOWN = 1; // Link went down
  localparam int PML_E_SYNC_LOST = 2; // Receive sync lost
  localparam int PML_NUM_EVENTS = 3; // Event count

  // ************************************************************
  // Reset values and rate codes
  // ************************************************************
  localparam logic [1:0] PML_RATE_1G = 2'h2; // 1 Gb/s
  localparam logic [1:0] PML_RATE_100M = 2'h1; // 100 Mb/s
  localparam logic [1:0] PML_RATE_10M = 2'h0; // 10 Mb/s
  localparam logic [7:0] PML_CTRL_RST = 8'h81; // Autoneg on, 1 Gb/s

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int PML_CLK_PERIOD_NS = 40; // 25 MHz clock
  localparam int PML_LT_GBE_NS = 10000000; // Gigabit link timer
  localparam int PML_LT_SGMII_NS = 1600000; // Serial-MII link timer
  localparam int PML_LT_GBE_CYC = PML_LT_GBE_NS / PML_CLK_PERIOD_NS;
  localparam int PML_LT_SGMII_CYC = PML_LT_SGMII_NS / PML_CLK_PERIOD_NS;
  localparam int PML_LT_SHORT_CYC = 64; // Debug link timer

  // Autoneg machine states
  typedef enum logic [2:0] {
    PML_AN_ENABLE,
    PML_AN_RESTART,
    PML_ABILITY_DET,
    PML_ACK_DET,
    PML_COMPLETE_ACK,
    PML_IDLE_DET,
    PML_LINK_OK,
    PML_DISABLE_LINK_OK
  } pml_an_state_t;

endpackage

// [hdl/pml_link_timer.sv]
/*
  Auto-negotiation link timer: counts from a start pulse to one of
  three limits and then holds its done flag.
  Assumes start is a one-cycle pulse from logic on the same clock.
*/
`timescale 1ns/1ps
module pml_link_timer
  import pml_pkg::*;
#(
  parameter int GBE_CYC = PML_LT_GBE_CYC,
  parameter int SGMII_CYC = PML_LT_SGMII_CYC,
  parameter int SHORT_CYC = PML_LT_SHORT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic short_mode,
  input wire logic gbe_mode,
  output logic done
);
  localparam int CW = $clog2(GBE_CYC + 1); // Counter width

  // ************************************************************
  // Parameter check
  // ************************************************************
  if (SHORT_CYC < 1 || SGMII_CYC < 1 || GBE_CYC < SGMII_CYC) begin : g_chk
    $error("link timer limits out of range");
  end

  logic [CW-1:0] cnt_q; // Elapsed cycles
  logic [CW-1:0] limit; // Active limit

  // Limit select, short debug mode first
  always_comb begin
    if (short_mode) begin
      limit = CW'(SHORT_CYC);
    end else if (gbe_mode) begin
      limit = CW'(GBE_CYC);
    end else begin
      limit = CW'(SGMII_CYC);
    end
  end

  // Counter, saturating at the active limit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (start) begin
      cnt_q <= '0;
    end else if (cnt_q >= limit) begin
      cnt_q <= limit;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Done flag
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      done <= 1'b0;
    end else begin
      done <= !start && (cnt_q >= limit);
    end
  end

  // Short mode bounds the count
  short_timer_a: assert property (@(posedge clk) disable iff (!rst_n)
    (short_mode && $past(short_mode) && !start) |-> (cnt_q <= CW'(SHORT_CYC)))
    else $error("short link timer exceeded");

endmodule // pml_link_timer

// [testbench/pml_far_end_model.sv]
/*
  Far-end model: the link partner as seen through the receive status levels.
  Assumes the bench sets its controls and xmit_an comes from the block.
*/
`timescale 1ns/1ps
module pml_far_end_model (
  input wire logic clk,
  input wire logic sync_en,
  input wire logic inv,
  input wire logic [7:0] cfg_len,
  input wire logic [7:0] ack_dly,
  input wire logic xmit_an,
  output logic rx_sync,
  output logic rx_invalid,
  output logic rx_cfg_valid,
  output logic rx_cfg_ack,
  output logic rx_idle
);
  // ************************************************************
  // Config exchange timing
  // ************************************************************
  logic [7:0] cnt_q; // Cycles of config exchange so far
  // Count while the block negotiates, restart when it stops
  always_ff @(posedge clk) begin
    if (!sync_en || !xmit_an) begin
      cnt_q <= 8'h00;
    end else if (cnt_q != 8'hff) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  // Config first, ack after a prompt or slow delay, then idles
  always_comb begin
    rx_sync = sync_en;
    rx_invalid = inv;
    rx_cfg_valid = sync_en && xmit_an && (cnt_q < cfg_len);
    rx_cfg_ack = rx_cfg_valid && (cnt_q >= ack_dly);
    rx_idle = sync_en && !rx_cfg_valid;
  end
endmodule // pml_far_end_model

// [testbench/tb_top.sv]
/*
  Self-checking bench for the mode control and link-status block.
  Assumes short link timers are set through the top-level parameters.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  $display("unexpected %s exp %0h got %0h", nm, e, g); error_cnt++; end end
module tb_top;
  import pml_pkg::*;
  // ************************************************************
  // Signals
  // ************************************************************
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteen = 4'h0;
  logic [31:0] rdata;
  logic waitreq;
  logic sync_en = 1'b0;
  logic inv = 1'b0;
  logic [7:0] cfg_len = 8'h14;
  logic [7:0] ack_dly = 8'h06;
  logic rx_sync, rx_invalid, rx_cfg_valid, rx_cfg_ack, rx_idle;
  logic link_good, an_complete, xmit_an, tx_ignore, gbe_mode, phy_side, irq;
  logic [1:0] rate_sel;
  logic [31:0] rnd_q = 32'h827f87ed; // Random state
  logic [31:0] exp_q[$]; // Expected read data
  logic [31:0] mon_exp;
  logic be0 = 1'b1; // Lane 0 enable for the next transfer
  int error_cnt = 0;
  int n_checks = 0;
  // Clock
  always #20 clk = ~clk;
  pml_mode_link_top #(.LT_GBE_CYC(200), .LT_SGMII_CYC(100), .LT_SHORT_CYC(8)) i_dut (
    .CLOCK(clk), .RESETN(rst_n), .ADDRESS(address), .READ(read), .WRITE(write),
    .WRITEDATA(writedata), .BYTEENABLE(byteen), .READDATA(rdata), .WAITREQUEST(waitreq),
    .RX_SYNC(rx_sync), .RX_INVALID(rx_invalid), .RX_CONFIG_VALID(rx_cfg_valid),
    .RX_CONFIG_ACK(rx_cfg_ack), .RX_IDLE(rx_idle), .LINK_GOOD(link_good),
    .AN_COMPLETE(an_complete), .XMIT_AUTONEG(xmit_an), .TX_IGNORE_GMII(tx_ignore),
    .RATE_SEL(rate_sel), .GBE_MODE(gbe_mode), .PHY_SIDE(phy_side), .IRQ(irq));
  pml_far_end_model i_far (
    .clk(clk), .sync_en(sync_en), .inv(inv), .cfg_len(cfg_len), .ack_dly(ack_dly),
    .xmit_an(xmit_an), .rx_sync(rx_sync), .rx_invalid(rx_invalid),
    .rx_cfg_valid(rx_cfg_valid), .rx_cfg_ack(rx_cfg_ack), .rx_idle(rx_idle));
  // ************************************************************
  // Tasks
  // ************************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                     input logic [31:0] e);
    int n;
    rnd_q = xs(rnd_q);
    address <= a;
    write <= wr;
    read <= !wr;
    writedata <= {rnd_q[31:8], d};
    byteen <= {rnd_q[3:1], be0};
    if (!wr) exp_q.push_back(e);
    n = 0;
    do begin @(posedge clk); n++; end while (waitreq !== 1'b0 && n < 20);
    if (n >= 20) error_cnt++;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_link(input logic v, input int lim, output int c);
    c = 0;
    while (link_good !== v && c < lim) begin @(posedge clk); c++; end
  endtask
  task automatic report_and_stop;
    if (exp_q.size() != 0) error_cnt++;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Read monitor takes the oldest note when read data stand
  always @(posedge clk) begin
    if (read === 1'b1 && waitreq === 1'b0) begin
      mon_exp = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hffffffff;
      `CHK("readdata", mon_exp, rdata)
    end
  end
  // Watchdog
  initial begin
    cyc(5000);
    error_cnt++;
    report_and_stop;
  end
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    int c;
    logic g, role;
    logic [1:0] sp;
    cyc(5);
    `CHK("rst_link", 1'b0, link_good)
    `CHK("rst_rate", PML_RATE_1G, rate_sel)
    `CHK("rst_wait", 1'b1, waitreq)
    rst_n <= 1'b1;
    cyc(2);
    bus(1'b0, PML_CTRL_OFS, 8'h00, {24'h0, PML_CTRL_RST});
    bus(1'b0, 4'h2, 8'h00, 32'h0);
    // Mode table while the link is down, speed code 11 never used
    for (int i = 0; i < 6; i++) begin
      g = i[0];
      sp = (i < 2) ? PML_RATE_10M : (i < 4) ? PML_RATE_100M : PML_RATE_1G;
      role = rnd_q[0];
      bus(1'b1, PML_CTRL_OFS, {sp, g, role, 4'h1}, 32'h0);
      cyc(2);
      if (g) `CHK("rate_gbe", PML_RATE_1G, rate_sel)
      else `CHK("rate_sgmii", sp, rate_sel)
      `CHK("phy_side", role & !g, phy_side)
      `CHK("gbe_mode", g, gbe_mode)
    end
    // Short timer, slow partner ack, masked then unmasked event
    bus(1'b1, PML_CTRL_OFS, 8'h89, 32'h0);
    sync_en <= 1'b1;
    wait_link(1'b1, 100, c);
    `CHK("fast_an", 1'b1, c < 60)
    `CHK("an_done", 1'b1, an_complete)
    `CHK("irq_masked", 1'b0, irq)
    bus(1'b0, PML_STAT_OFS, 8'h00, 32'h207);
    bus(1'b1, PML_INTM_OFS, 8'h01, 32'h0);
    cyc(2);
    `CHK("irq_on", 1'b1, irq)
    bus(1'b1, PML_INTS_OFS, 8'h01, 32'h0);
    cyc(2);
    `CHK("irq_clr", 1'b0, irq)
    // Restart from link ok with a prompt partner
    ack_dly <= 8'h00;
    bus(1'b1, PML_CTRL_OFS, 8'h8b, 32'h0);
    wait_link(1'b0, 10, c);
    `CHK("restart_drop", 1'b0, link_good)
    `CHK("restart_xmit", 1'b1, xmit_an)
    wait_link(1'b1, 100, c);
    `CHK("relink", 1'b1, link_good)
    // Down and up events both latched, only up unmasked
    bus(1'b0, PML_INTS_OFS, 8'h00, 32'h3);
    bus(1'b0, PML_INTM_OFS, 8'h00, 32'h1);
    `CHK("irq_relink", 1'b1, irq)
    // Write with lane 0 disabled is refused
    be0 = 1'b0;
    bus(1'b1, PML_CTRL_OFS, 8'h00, 32'h0);
    be0 = 1'b1;
    bus(1'b0, PML_CTRL_OFS, 8'h00, 32'h89);
    // Normal link timer is far slower
    cfg_len <= 8'h96;
    bus(1'b1, PML_CTRL_OFS, 8'h83, 32'h0);
    wait_link(1'b0, 10, c);
    wait_link(1'b1, 800, c);
    `CHK("slow_an", 1'b1, c > 150 && link_good === 1'b1)
    // Sync loss drops the link, then autoneg off gives disabled link ok
    sync_en <= 1'b0;
    wait_link(1'b0, 10, c);
    `CHK("sync_drop", 1'b0, link_good)
    bus(1'b1, PML_CTRL_OFS, 8'h88, 32'h0);
    wait_link(1'b1, 10, c);
    `CHK("dis_link", 1'b1, link_good)
    `CHK("dis_an_done", 1'b0, an_complete)
    `CHK("dis_xmit", 1'b0, xmit_an)
    // Transmit gating and the unidirectional override
    cyc(2);
    `CHK("tx_nosync", 1'b1, tx_ignore)
    sync_en <= 1'b1;
    inv <= 1'b1;
    cyc(3);
    `CHK("tx_invalid", 1'b1, tx_ignore)
    sync_en <= 1'b0;
    bus(1'b1, PML_CTRL_OFS, 8'h8c, 32'h0);
    cyc(2);
    `CHK("tx_unidir", 1'b0, tx_ignore)
    bus(1'b1, PML_CTRL_OFS, 8'h88, 32'h0);
    cyc(2);
    `CHK("tx_unidir_end", 1'b1, tx_ignore)
    inv <= 1'b0;
    sync_en <= 1'b1;
    cyc(3);
    `CHK("tx_run", 1'b0, tx_ignore)
    // Reset in mid-run
    rst_n <= 1'b0;
    cyc(2);
    `CHK("rst2_link", 1'b0, link_good)
    rst_n <= 1'b1;
    cyc(2);
    bus(1'b0, PML_CTRL_OFS, 8'h00, {24'h0, PML_CTRL_RST});
    cyc(2);
    report_and_stop;
  end
endmodule // tb_top
